/* hdl/isvm_top.v */
`timescale 1ns/1ns
`include "isvm_regs.vh"
module isvm_top #(
   parameter NSRC = `ISVM_NUM_MASKABLE,
   parameter NRST = `ISVM_NUM_RESET
) (
   input  wire               clk_i,
   input  wire               rst_n_i,
   input  wire               watchdog_interval_req_i,
   input  wire               voltage_detect_req_i,
   input  wire               pin_edge_req_0_i,
   input  wire               pin_edge_req_1_i,
   input  wire               pin_edge_req_2_i,
   input  wire               pin_edge_req_3_i,
   input  wire               pin_edge_req_4_i,
   input  wire               pin_edge_req_5_i,
   input  wire               serial0_tx_req_i,
   input  wire               clocked_serial0_req_i,
   input  wire               two_wire0_req_i,
   input  wire               serial0_rx_req_i,
   input  wire               serial0_rx_err_req_i,
   input  wire               timer_ch1_upper_req_i,
   input  wire               serial1_tx_req_i,
   input  wire               serial1_rx_req_i,
   input  wire               serial1_rx_err_req_i,
   input  wire               timer_ch3_upper_req_i,
   input  wire               timer_ch0_end_req_i,
   input  wire               timer_ch1_end_req_i,
   input  wire               timer_ch2_end_req_i,
   input  wire               timer_ch3_end_req_i,
   input  wire               conversion_done_req_i,
   input  wire               dual_timer0_req_i,
   input  wire               dual_timer1_req_i,
   input  wire               flash_sequencer_req_i,
   input  wire               software_break_i,
   input  wire [NRST-1:0]    reset_cause_i,
   input  wire [NSRC-1:0]    mask_i,
   input  wire [2*NSRC-1:0]  group_i,
   input  wire               int_enable_i,
   input  wire [2:0]         service_level_i,
   input  wire               ack_i,
   output reg                branch_req_o,
   output reg  [15:0]        vector_o,
   output reg  [1:0]         kind_o,
   output reg  [5:0]         default_prio_o,
   output reg  [1:0]         group_o,
   output reg  [NSRC-1:0]    pending_o
);

   localparam NSLOT = NSRC + 2;

   // slot order follows default priority, so a lower slot wins ties
   wire [NSLOT-1:0] set_vec;
   wire [NSLOT-1:0] flag_vec;
   reg  [NSLOT-1:0] clr_vec;
   reg  [4:0]       pres_slot;

   // merge shared sources by OR
   assign set_vec[0]  = watchdog_interval_req_i;
   assign set_vec[1]  = voltage_detect_req_i;
   assign set_vec[2]  = pin_edge_req_0_i;
   assign set_vec[3]  = pin_edge_req_1_i;
   assign set_vec[4]  = pin_edge_req_2_i;
   assign set_vec[5]  = pin_edge_req_3_i;
   assign set_vec[6]  = pin_edge_req_4_i;
   assign set_vec[7]  = pin_edge_req_5_i;
   assign set_vec[8]  = serial0_tx_req_i | clocked_serial0_req_i
                        | two_wire0_req_i;
   assign set_vec[9]  = serial0_rx_req_i | serial0_rx_err_req_i;
   assign set_vec[10] = timer_ch1_upper_req_i;
   assign set_vec[11] = serial1_tx_req_i;
   assign set_vec[12] = serial1_rx_req_i | serial1_rx_err_req_i;
   assign set_vec[13] = timer_ch3_upper_req_i;
   assign set_vec[14] = timer_ch0_end_req_i;
   assign set_vec[15] = timer_ch1_end_req_i;
   assign set_vec[16] = timer_ch2_end_req_i;
   assign set_vec[17] = timer_ch3_end_req_i;
   assign set_vec[18] = conversion_done_req_i;
   assign set_vec[19] = dual_timer0_req_i;
   assign set_vec[20] = dual_timer1_req_i;
   assign set_vec[21] = flash_sequencer_req_i;
   assign set_vec[NSRC]   = software_break_i;
   assign set_vec[NSRC+1] = |reset_cause_i;

   // one pending flag per slot
   genvar g;
   generate
      for (g = 0; g < NSLOT; g = g + 1) begin : flags
         isvm_flag u_flag (
            .clk_i   (clk_i),
            .rst_n_i (rst_n_i),
            .set_i   (set_vec[g]),
            .clr_i   (clr_vec[g]),
            .flag_o  (flag_vec[g])
         );
      end
   endgenerate

   // vector table entry of a slot, two bytes per entry
   function [15:0] vec_of;
      input [4:0] slot;
      begin
         if (slot <= 5'h07) begin
            vec_of = `ISVM_VEC_WDT
                     + {10'h000, slot, 1'b0};
         end else if (slot >= 5'h0e && slot <= 5'h11) begin
            vec_of = `ISVM_VEC_TM0_END
                     + {10'h000, slot - 5'h0e, 1'b0};
         end else begin
            case (slot)
               5'h08:   vec_of = `ISVM_VEC_SER0_TX;
               5'h09:   vec_of = `ISVM_VEC_SER0_RX;
               5'h0a:   vec_of = `ISVM_VEC_TM1_UP;
               5'h0b:   vec_of = `ISVM_VEC_SER1_TX;
               5'h0c:   vec_of = `ISVM_VEC_SER1_RX;
               5'h0d:   vec_of = `ISVM_VEC_TM3_UP;
               5'h12:   vec_of = `ISVM_VEC_ADC;
               5'h13:   vec_of = `ISVM_VEC_DTM0;
               5'h14:   vec_of = `ISVM_VEC_DTM1;
               5'h15:   vec_of = `ISVM_VEC_FLASH;
               5'h16:   vec_of = `ISVM_VEC_BREAK;
               default: vec_of = `ISVM_VEC_RESET;
            endcase
         end
      end
   endfunction

   // default priority number of a slot
   function [5:0] dprio_of;
      input [4:0] slot;
      begin
         if (slot <= 5'h07) begin
            dprio_of = {1'b0, slot};
         end else if (slot >= 5'h0e && slot <= 5'h11) begin
            dprio_of = `ISVM_DP_TM0_END
                       + {1'b0, slot - 5'h0e};
         end else begin
            case (slot)
               5'h08:   dprio_of = `ISVM_DP_SER0_TX;
               5'h09:   dprio_of = `ISVM_DP_SER0_RX;
               5'h0a:   dprio_of = `ISVM_DP_TM1_UP;
               5'h0b:   dprio_of = `ISVM_DP_SER1_TX;
               5'h0c:   dprio_of = `ISVM_DP_SER1_RX;
               5'h0d:   dprio_of = `ISVM_DP_TM3_UP;
               5'h12:   dprio_of = `ISVM_DP_ADC;
               5'h13:   dprio_of = `ISVM_DP_DTM0;
               5'h14:   dprio_of = `ISVM_DP_DTM1;
               5'h15:   dprio_of = `ISVM_DP_FLASH;
               default: dprio_of = `ISVM_DP_NONE;
            endcase
         end
      end
   endfunction

   // maskable arbitration: best group first, lowest slot on a tie
   reg [4:0]  best_slot;
   reg [1:0]  best_grp;
   reg        best_hit;
   reg [1:0]  cur_grp;
   integer    i;

   always @* begin
      best_slot = 5'h00;
      best_grp  = 2'h3;
      best_hit  = 1'b0;
      cur_grp   = 2'h0;
      for (i = NSRC - 1; i >= 0; i = i - 1) begin
         cur_grp = group_i[2*i +: 2];
         if (flag_vec[i] && !mask_i[i]
             && ({1'b0, cur_grp} < service_level_i)
             && (!best_hit || cur_grp <= best_grp)) begin
            best_slot = i[4:0];
            best_grp  = cur_grp;
            best_hit  = 1'b1;
         end
      end
   end

   // final choice: reset, then break, then enabled maskable
   reg        next_req;
   reg [4:0]  next_slot;
   reg [1:0]  next_kind;
   reg [1:0]  next_grp;

   always @* begin
      next_req  = 1'b0;
      next_slot = best_slot;
      next_kind = `ISVM_KIND_MASKABLE;
      next_grp  = best_grp;
      if (flag_vec[NSRC+1]) begin
         next_req  = 1'b1;
         next_slot = `ISVM_SLOT_RST;
         next_kind = `ISVM_KIND_RESET;
         next_grp  = `ISVM_GROUP_RESET;
      end else if (flag_vec[NSRC]) begin
         next_req  = 1'b1;
         next_slot = `ISVM_SLOT_BREAK;
         next_kind = `ISVM_KIND_BREAK;
         next_grp  = `ISVM_GROUP_RESET;
      end else if (best_hit && int_enable_i) begin
         next_req  = 1'b1;
      end
   end

   // acknowledge clears the presented slot only
   integer k;
   always @* begin
      clr_vec = {NSLOT{1'b0}};
      for (k = 0; k < NSLOT; k = k + 1) begin
         if (ack_i && branch_req_o && pres_slot == k[4:0]) begin
            clr_vec[k] = 1'b1;
         end
      end
   end

   // present the winner; drop for one cycle after an acknowledge
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         branch_req_o   <= 1'b0;
         vector_o       <= `ISVM_VEC_RESET;
         kind_o         <= `ISVM_KIND_MASKABLE;
         default_prio_o <= `ISVM_DP_NONE;
         group_o        <= 2'h0;
         pres_slot      <= 5'h00;
      end else if (ack_i && branch_req_o) begin
         branch_req_o   <= 1'b0;
      end else begin
         branch_req_o   <= next_req;
         vector_o       <= vec_of(next_slot);
         kind_o         <= next_kind;
         default_prio_o <= dprio_of(next_slot);
         group_o        <= next_grp;
         pres_slot      <= next_slot;
      end
   end

   // pending maskable flags shown for software polling
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pending_o <= {NSRC{1'b0}};
      end else begin
         pending_o <= flag_vec[NSRC-1:0];
      end
   end

endmodule

/* common/isvm_regs.vh */
`ifndef ISVM_REGS_VH
`define ISVM_REGS_VH

// counts of sources handled by the map
`define ISVM_NUM_MASKABLE    22
`define ISVM_NUM_RESET       5
`define ISVM_SLOT_BREAK      5'h16
`define ISVM_SLOT_RST        5'h17

// branch kinds shown to the core
`define ISVM_KIND_MASKABLE   2'h0
`define ISVM_KIND_BREAK      2'h1
`define ISVM_KIND_RESET      2'h2

// in-service level meaning nothing is being serviced
`define ISVM_LEVEL_IDLE      3'h4
`define ISVM_GROUP_RESET     2'h0

// fixed vector addresses
`define ISVM_VEC_RESET       16'h0000
`define ISVM_VEC_BREAK       16'h007e
`define ISVM_VEC_WDT         16'h0004
`define ISVM_VEC_LVD         16'h0006
`define ISVM_VEC_PIN0        16'h0008
`define ISVM_VEC_PIN5        16'h0012
`define ISVM_VEC_SER0_TX     16'h001e
`define ISVM_VEC_SER0_RX     16'h0020
`define ISVM_VEC_TM1_UP      16'h0022
`define ISVM_VEC_SER1_TX     16'h0024
`define ISVM_VEC_SER1_RX     16'h0026
`define ISVM_VEC_TM3_UP      16'h0028
`define ISVM_VEC_TM0_END     16'h002c
`define ISVM_VEC_TM3_END     16'h0032
`define ISVM_VEC_ADC         16'h0034
`define ISVM_VEC_DTM0        16'h0056
`define ISVM_VEC_DTM1        16'h0058
`define ISVM_VEC_FLASH       16'h0062
`define ISVM_VEC_STEP        16'h0002

// default priority numbers, zero highest
`define ISVM_DP_WDT          6'h00
`define ISVM_DP_LVD          6'h01
`define ISVM_DP_PIN0         6'h02
`define ISVM_DP_SER0_TX      6'h0b
`define ISVM_DP_SER0_RX      6'h0c
`define ISVM_DP_TM1_UP       6'h0d
`define ISVM_DP_SER1_TX      6'h0e
`define ISVM_DP_SER1_RX      6'h0f
`define ISVM_DP_TM3_UP       6'h10
`define ISVM_DP_TM0_END      6'h12
`define ISVM_DP_ADC          6'h16
`define ISVM_DP_DTM0         6'h27
`define ISVM_DP_DTM1         6'h28
`define ISVM_DP_FLASH        6'h2c
`define ISVM_DP_NONE         6'h3f

`endif

/* hdl/isvm_flag.v */
`timescale 1ns/1ns
// one pending-request flag; a set in the clear cycle wins
module isvm_flag (
   input  wire clk_i,
   input  wire rst_n_i,
   input  wire set_i,
   input  wire clr_i,
   output reg  flag_o
);

   // sticky request with set priority over clear
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flag_o <= 1'b0;
      end else if (set_i) begin
         flag_o <= 1'b1;
      end else if (clr_i) begin
         flag_o <= 1'b0;
      end
   end

endmodule

/* bench/isvm_top_properties.sv */
`timescale 1ns/1ns
// watches the branch outputs of the source map at the core side
module isvm_top_properties #(
   parameter NSRC = 22,
   parameter NRST = 5
) (
   input wire              clk_i,
   input wire              rst_n_i,
   input wire              watchdog_interval_req_i,
   input wire              flash_sequencer_req_i,
   input wire [NRST-1:0]   reset_cause_i,
   input wire [NSRC-1:0]   mask_i,
   input wire [2*NSRC-1:0] group_i,
   input wire              int_enable_i,
   input wire [2:0]        service_level_i,
   input wire              ack_i,
   input wire              branch_req_o,
   input wire [15:0]       vector_o,
   input wire [1:0]        kind_o,
   input wire [5:0]        default_prio_o,
   input wire [NSRC-1:0]   pending_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   // every target is an even address inside the table
   a_vec_in_table: assert property (branch_req_o |->
      vector_o[0] == 1'b0 && vector_o <= 16'h007e)
      else $error("vector outside table");
   // any reset cause becomes a reset branch within three edges
   a_reset_branch: assert property (|reset_cause_i |->
      ##[2:3] branch_req_o && kind_o == 2'h2)
      else $error("reset cause not presented");
   // reset branches go to the bottom of the table
   a_reset_vector: assert property (branch_req_o && kind_o == 2'h2 |->
      vector_o == 16'h0000)
      else $error("reset vector wrong");
   // break has a fixed entry and no default priority
   a_break_vector: assert property (branch_req_o && kind_o == 2'h1 |->
      vector_o == 16'h007e && default_prio_o == 6'h3f)
      else $error("break vector wrong");
   // watchdog entry carries the top default priority
   a_wdt_prio: assert property (branch_req_o && vector_o == 16'h0004 |->
      default_prio_o == 6'h00 && kind_o == 2'h0)
      else $error("watchdog priority wrong");
   // flash sequencer entry carries the lowest default priority
   a_flash_prio: assert property (
      branch_req_o && vector_o == 16'h0062 |-> default_prio_o == 6'h2c)
      else $error("flash priority wrong");
   // an accepted branch drops for a cycle
   a_ack_gap: assert property (ack_i && branch_req_o |=> !branch_req_o)
      else $error("branch held after ack");
   // an allowed watchdog request is presented two edges later
   a_wdt_answer: assert property (
      watchdog_interval_req_i && !mask_i[0] && int_enable_i && !branch_req_o
      && group_i[1:0] < service_level_i && !ack_i ##1 !ack_i
      |-> ##1 branch_req_o)
      else $error("watchdog request not presented");
   // a masked request is still remembered
   a_masked_pend: assert property (
      flash_sequencer_req_i && mask_i[21] |-> ##2 pending_o[21])
      else $error("masked request lost");

   c_reset: cover property (branch_req_o && kind_o == 2'h2);
   c_break: cover property (branch_req_o && kind_o == 2'h1);
   c_accept: cover property (ack_i && branch_req_o);
endmodule

bind isvm_top isvm_top_properties #(.NSRC(NSRC), .NRST(NRST)) u_props (
   .clk_i(clk_i), .rst_n_i(rst_n_i),
   .watchdog_interval_req_i(watchdog_interval_req_i),
   .flash_sequencer_req_i(flash_sequencer_req_i),
   .reset_cause_i(reset_cause_i), .mask_i(mask_i), .group_i(group_i),
   .int_enable_i(int_enable_i), .service_level_i(service_level_i),
   .ack_i(ack_i), .branch_req_o(branch_req_o), .vector_o(vector_o),
   .kind_o(kind_o), .default_prio_o(default_prio_o), .pending_o(pending_o)
);

/* bench/isvm_core_model.sv */
`timescale 1ns/1ns
// core stand-in: takes each presented branch after delay_i waiting cycles
module isvm_core_model (
   input  wire       clk_i,
   input  wire       rst_n_i,
   input  wire       branch_req_i,
   input  wire [3:0] delay_i,
   output logic      ack_o
);
   logic [3:0] wait_cnt;

   // count while a branch stands, pulse ack once, never twice in a row
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wait_cnt <= 4'h0;
         ack_o    <= 1'b0;
      end else begin
         ack_o <= 1'b0;
         if (branch_req_i && !ack_o && wait_cnt == delay_i) begin
            ack_o    <= 1'b1;
            wait_cnt <= 4'h0;
         end else if (branch_req_i && !ack_o) begin
            wait_cnt <= wait_cnt + 4'h1;
         end else begin
            wait_cnt <= 4'h0;
         end
      end
   end
endmodule

/* bench/isvm_top_tb.sv */
`timescale 1ns/1ns
// self-checking bench for the interrupt source map
module isvm_top_tb;
   logic        clk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic [25:0] src = 26'h0;
   logic        sw_break = 1'b0;
   logic [4:0]  rcause = 5'h0;
   logic [21:0] mask = 22'h0;
   logic [43:0] grp = 44'h0;
   logic        ien = 1'b1;
   logic [2:0]  slevel = 3'h4;
   logic [3:0]  delay = 4'h0;
   wire         ack;
   wire         breq;
   wire [15:0]  vec;
   wire [1:0]   kind;
   wire [5:0]   prio;
   wire [1:0]   grp_o;
   wire [21:0]  pend;
   int          n_mismatch = 0;
   int          checked = 0;
   int          cyc = 0;
   logic [15:0] vt [26] = '{16'h0004, 16'h0006, 16'h0008, 16'h000a,
      16'h000c, 16'h000e, 16'h0010, 16'h0012, 16'h001e, 16'h001e, 16'h001e,
      16'h0020, 16'h0020, 16'h0022, 16'h0024, 16'h0026, 16'h0026, 16'h0028,
      16'h002c, 16'h002e, 16'h0030, 16'h0032, 16'h0034, 16'h0056, 16'h0058,
      16'h0062};
   logic [5:0]  pt [26] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06,
      6'h07, 6'h0b, 6'h0b, 6'h0b, 6'h0c, 6'h0c, 6'h0d, 6'h0e, 6'h0f, 6'h0f,
      6'h10, 6'h12, 6'h13, 6'h14, 6'h15, 6'h16, 6'h27, 6'h28, 6'h2c};

   isvm_top u_dut (
      .clk_i(clk_i), .rst_n_i(rst_n_i),
      .watchdog_interval_req_i(src[0]), .voltage_detect_req_i(src[1]),
      .pin_edge_req_0_i(src[2]), .pin_edge_req_1_i(src[3]),
      .pin_edge_req_2_i(src[4]), .pin_edge_req_3_i(src[5]),
      .pin_edge_req_4_i(src[6]), .pin_edge_req_5_i(src[7]),
      .serial0_tx_req_i(src[8]), .clocked_serial0_req_i(src[9]),
      .two_wire0_req_i(src[10]), .serial0_rx_req_i(src[11]),
      .serial0_rx_err_req_i(src[12]), .timer_ch1_upper_req_i(src[13]),
      .serial1_tx_req_i(src[14]), .serial1_rx_req_i(src[15]),
      .serial1_rx_err_req_i(src[16]), .timer_ch3_upper_req_i(src[17]),
      .timer_ch0_end_req_i(src[18]), .timer_ch1_end_req_i(src[19]),
      .timer_ch2_end_req_i(src[20]), .timer_ch3_end_req_i(src[21]),
      .conversion_done_req_i(src[22]), .dual_timer0_req_i(src[23]),
      .dual_timer1_req_i(src[24]), .flash_sequencer_req_i(src[25]),
      .software_break_i(sw_break), .reset_cause_i(rcause), .mask_i(mask),
      .group_i(grp), .int_enable_i(ien), .service_level_i(slevel),
      .ack_i(ack), .branch_req_o(breq), .vector_o(vec), .kind_o(kind),
      .default_prio_o(prio), .group_o(grp_o), .pending_o(pend)
   );

   isvm_core_model u_core (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .branch_req_i(breq),
      .delay_i(delay), .ack_o(ack)
   );

   always #2 clk_i = ~clk_i;

   // cut a hang short
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         n_mismatch++;
         stop_test();
      end
   end

   task automatic chk(input string what, input logic [15:0] seen,
                      input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one-cycle pulse on sources, break and reset causes
   task automatic fire(input logic [25:0] m, input logic b,
                       input logic [4:0] r);
      @(posedge clk_i);
      src <= m;
      sw_break <= b;
      rcause <= r;
      @(posedge clk_i);
      src <= 26'h0;
      sw_break <= 1'b0;
      rcause <= 5'h0;
   endtask

   // wait for a presented branch, judge it, then let the core take it
   task automatic get(input logic [15:0] v, input logic [5:0] p,
                      input logic [1:0] kd, input logic [1:0] g);
      int n;
      n = 0;
      do begin
         @(posedge clk_i);
         #1;
         n++;
      end while (breq !== 1'b1 && n < 12);
      chk("branch", breq, 1'b1);
      chk("vector", vec, v);
      chk("prio", prio, p);
      chk("kind", kind, kd);
      chk("group", grp_o, g);
      n = 0;
      while (breq !== 1'b0 && n < 24) begin
         @(posedge clk_i);
         #1;
         n++;
      end
   endtask

   task automatic t_sources();
      for (int k = 0; k < 26; k++) begin
         fire(26'h1 << k, 1'b0, 5'h0);
         get(vt[k], pt[k], 2'h0, 2'h0);
      end
      $display("sources test done");
   endtask

   task automatic t_order();
      @(posedge clk_i);
      delay <= 4'h5;
      fire(26'h2000001, 1'b0, 5'h0);
      get(16'h0004, 6'h00, 2'h0, 2'h0);
      get(16'h0062, 6'h2c, 2'h0, 2'h0);
      @(posedge clk_i);
      grp <= 44'h3;
      fire(26'h2000001, 1'b0, 5'h0);
      get(16'h0062, 6'h2c, 2'h0, 2'h0);
      get(16'h0004, 6'h00, 2'h0, 2'h3);
      @(posedge clk_i);
      grp <= 44'h0;
      delay <= 4'h0;
      $display("order test done");
   endtask

   task automatic t_special();
      @(posedge clk_i);
      ien <= 1'b0;
      fire(26'h4, 1'b1, 5'h0);
      get(16'h007e, 6'h3f, 2'h1, 2'h0);
      repeat (4) @(posedge clk_i);
      #1;
      chk("disabled idle", breq, 1'b0);
      chk("pin pend", pend[2], 1'b1);
      for (int i = 0; i < 5; i++) begin
         fire(26'h0, 1'b1, 5'h1 << i);
         get(16'h0000, 6'h3f, 2'h2, 2'h0);
         get(16'h007e, 6'h3f, 2'h1, 2'h0);
      end
      @(posedge clk_i);
      ien <= 1'b1;
      get(16'h0008, 6'h02, 2'h0, 2'h0);
      $display("break and reset test done");
   endtask

   task automatic t_refused();
      @(posedge clk_i);
      mask <= 22'h200000;
      slevel <= 3'h1;
      grp <= 44'h10;
      fire(26'h2000004, 1'b0, 5'h0);
      repeat (4) @(posedge clk_i);
      #1;
      chk("held", breq, 1'b0);
      chk("flash pend", pend[21], 1'b1);
      @(posedge clk_i);
      slevel <= 3'h2;
      get(16'h0008, 6'h02, 2'h0, 2'h1);
      @(posedge clk_i);
      mask <= 22'h0;
      get(16'h0062, 6'h2c, 2'h0, 2'h0);
      $display("refusal test done");
   endtask

   task automatic stop_test();
      $display("compares %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   initial begin
      repeat (12) @(posedge clk_i);
      rst_n_i <= 1'b1;
      t_sources();
      t_order();
      t_special();
      t_refused();
      stop_test();
   end
endmodule
